//--- pkg/i2ts_pkg.sv
package i2ts_pkg;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_MASK = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_THR = 8'h44;
  localparam logic [ADDR_W-1:0] OFF_CLEAR = 8'h48;
  localparam logic [ADDR_W-1:0] OFF_TXDATA = 8'h4c;

  // ----------------------------------------------------------------
  // fifo geometry
  // ----------------------------------------------------------------
  localparam int TX_DEPTH = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
  localparam logic [CNT_W-1:0] THR_RST = 5'h00;

  // ----------------------------------------------------------------
  // status, mask and control bit positions, reset values
  // ----------------------------------------------------------------
  localparam int BIT_EMPTY = 0;
  localparam int BIT_NEMPTY = 1;
  localparam int BIT_FULL = 2;
  localparam int BIT_OVR = 3;
  localparam int BIT_MDNS = 28;
  localparam int BIT_FLUSH = 0;
  localparam logic [31:0] MASK_RW = 32'h1fff_ffff;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic OVR_RST = 1'b0;
  localparam logic MDNS_RST = 1'b0;

  // ----------------------------------------------------------------
  // bus answers and write states
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } i2ts_wr_t;

endpackage

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import i2ts_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tx_pop, mdns_ev;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, tx_word, seed;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, tx_push, tx_flush_bit, irq;
  int err_total, n_compared, cnt, thr, ovr, mdns, pushes, seen_push, seen_flush;
  logic [31:0] exp_q[$];
  logic [31:0] mask, rd;
  logic [1:0] rs;

  i2ts_top uut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .tx_push(tx_push), .tx_word(tx_word), .tx_pop(tx_pop), .tx_flush_bit(tx_flush_bit),
    .master_done_no_stop_event(mdns_ev), .irq(irq)
  );

  // ----------------------------------------
  // clock, random source, push monitor
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  always @(posedge aclk) begin
    if (tx_push === 1'b1) begin
      seen_push++;
      if (exp_q.size() == 0) chk("tx_word queue", 32'h0, 32'h1);
      else chk("tx_word", exp_q.pop_front(), tx_word);
    end
    if (tx_flush_bit === 1'b1) seen_flush++;
  end

  // ----------------------------------------
  // compare, bus cycles, model
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    bit ad, wd;
    t = 0;
    ad = 0;
    wd = 0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    while (!(ad && wd) && t < 64) begin
      @(posedge aclk);
      t++;
      if (!ad && awready === 1'b1) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
      t++;
    end while (bvalid !== 1'b1 && t < 64);
    chk("bvalid", 32'h1, {31'h0, bvalid});
    r = bresp;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
    end while (arready !== 1'b1 && t < 64);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      t++;
    end while (rvalid !== 1'b1 && t < 64);
    chk("rvalid", 32'h1, {31'h0, rvalid});
    d = rdata;
    r = rresp;
  endtask

  function automatic logic [31:0] exp_status();
    logic [31:0] s;
    s = 32'h0;
    s[BIT_EMPTY] = (cnt == 0);
    s[BIT_NEMPTY] = (cnt <= thr);
    s[BIT_FULL] = (cnt == TX_DEPTH);
    s[BIT_OVR] = (ovr != 0);
    s[BIT_MDNS] = (mdns != 0);
    return s;
  endfunction

  task automatic check_status();
    rd_reg(OFF_STATUS, rd, rs);
    chk("status rresp", RESP_OKAY, rs);
    chk("status", exp_status(), rd);
    chk("irq", {31'h0, (exp_status() & mask) != 0}, {31'h0, irq});
  endtask

  task automatic push();
    logic [31:0] w;
    w = rnd();
    if (cnt < TX_DEPTH) exp_q.push_back(w);
    wr(OFF_TXDATA, w, rs);
    if (cnt == TX_DEPTH) ovr = 1;
    else begin
      cnt++;
      pushes++;
    end
  endtask

  task automatic pop();
    tx_pop <= 1'b1;
    @(posedge aclk);
    tx_pop <= 1'b0;
    @(posedge aclk);
    if (cnt > 0) cnt--;
  endtask

  task automatic set_mask(input logic [31:0] m);
    wr(OFF_MASK, m, rs);
    chk("mask bresp", RESP_OKAY, rs);
    mask = m & MASK_RW;
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #(25ns * 20000);
    err_total++;
    results();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, arvalid, tx_pop, mdns_ev} = 6'h00;
    {bready, rready} = 2'h3;
    {awaddr, araddr, wstrb, wdata} = 52'h0;
    seed = 32'h0000_004c;
    {err_total, n_compared, cnt, thr, ovr, mdns, pushes} = 224'h0;
    mask = 32'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_status();
    rd_reg(OFF_MASK, rd, rs);
    chk("mask reset", 32'h0, rd);
    set_mask(32'hffff_ffff);
    rd_reg(OFF_MASK, rd, rs);
    chk("mask rw", 32'h1fff_ffff, rd);
    thr = int'(rnd() % 15);
    wr(OFF_THR, thr, rs);
    rd_reg(OFF_THR, rd, rs);
    chk("thr", thr, rd);
    set_mask(32'h1 << BIT_EMPTY);
    check_status();
    for (int i = 0; i < TX_DEPTH; i++) begin
      push();
      check_status();
    end
    set_mask(32'h1 << BIT_OVR);
    push();
    check_status();
    chk("pushes", pushes, seen_push);
    pop();
    pop();
    push();
    check_status();
    wr(OFF_CLEAR, 32'h1 << BIT_OVR, rs);
    ovr = 0;
    check_status();
    wr(OFF_CTRL, 32'h1, rs);
    cnt = 0;
    check_status();
    chk("flushes", 32'h1, seen_flush);
    set_mask(32'h1 << BIT_MDNS);
    mdns_ev <= 1'b1;
    @(posedge aclk);
    mdns_ev <= 1'b0;
    @(posedge aclk);
    mdns = 1;
    check_status();
    wr(OFF_CLEAR, 32'h1 << BIT_MDNS, rs);
    mdns = 0;
    check_status();
    wr(8'h00, 32'hffff_ffff, rs);
    chk("unmapped bresp", RESP_SLVERR, rs);
    rd_reg(8'h00, rd, rs);
    chk("unmapped rresp", RESP_SLVERR, rs);
    chk("unmapped rdata", 32'h0, rd);
    set_mask(32'hf);
    for (int i = 0; i < 40; i++) begin
      if (rnd() % 3 == 0) pop();
      else push();
      check_status();
    end
    chk("pushes", pushes, seen_push);
    results();
  end
endmodule

//--- src/i2ts_top.sv
`timescale 1ns/1ps
// Contract
// - empty flag bit0 high when fifo empty
// - empty flag drops once a word is written
// - nearly empty bit1 while count at or below threshold
// - nearly empty drops when count exceeds threshold
// - full flag bit2 follows fifo full, reset 0
// - write while full sets overrun bit3, drops word
// - overrun holds until clear register bit written
// - mask bit28 enables done-no-stop; 31:29 zero
// - mask bit per status flag enables it
module i2ts_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [i2ts_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [i2ts_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic tx_push,
  output logic [31:0] tx_word,
  input wire logic tx_pop,
  output logic tx_flush_bit,
  input wire logic master_done_no_stop_event,
  output logic irq
);
  import i2ts_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, OFF_MASK) | hit(a, OFF_STATUS) | hit(a, OFF_CTRL)
           | hit(a, OFF_THR) | hit(a, OFF_CLEAR) | hit(a, OFF_TXDATA);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  i2ts_wr_t wr_state_ff, nxt_wr_state;
  logic aw_hold_ff, nxt_aw_hold;
  logic [ADDR_W-1:0] aw_addr_ff, nxt_aw_addr;
  logic w_hold_ff, nxt_w_hold;
  logic [31:0] w_data_ff, nxt_w_data;
  logic [3:0] w_strb_ff, nxt_w_strb;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [CNT_W-1:0] thr_ff, nxt_thr;
  logic [31:0] mask_ff, nxt_mask;
  logic ovr_ff, nxt_ovr;
  logic mdns_ff, nxt_mdns;
  logic push_ff, nxt_push;
  logic [31:0] txw_ff, nxt_txw;
  logic flush_ff, nxt_flush;

  logic do_write;
  logic wr_data, wr_clear, wr_ctrl;
  logic full_now, push_ok, overrun_set, pop_ok;
  logic [31:0] status;
  logic [31:0] clr_bits;

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  always_comb begin
    status = 32'h0000_0000;
    status[BIT_EMPTY] = (cnt_ff == CNT_RST);
    status[BIT_NEMPTY] = (cnt_ff <= thr_ff);
    status[BIT_FULL] = (cnt_ff == CNT_FULL);
    status[BIT_OVR] = ovr_ff;
    status[BIT_MDNS] = mdns_ff;
  end

  assign irq = |(status & mask_ff);

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  assign awready = !aw_hold_ff && (wr_state_ff == WR_IDLE);
  assign wready = !w_hold_ff && (wr_state_ff == WR_IDLE);
  assign bvalid = (wr_state_ff == WR_RESP);
  assign bresp = bresp_ff;
  assign do_write = aw_hold_ff && w_hold_ff && (wr_state_ff == WR_IDLE);

  always_comb begin
    nxt_wr_state = wr_state_ff;
    nxt_aw_hold = aw_hold_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_hold = w_hold_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_bresp = bresp_ff;
    if (awvalid && awready) begin
      nxt_aw_hold = 1'b1;
      nxt_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_w_hold = 1'b1;
      nxt_w_data = wdata;
      nxt_w_strb = wstrb;
    end
    case (wr_state_ff)
      WR_IDLE: begin
        if (do_write) begin
          nxt_wr_state = WR_RESP;
          nxt_aw_hold = 1'b0;
          nxt_w_hold = 1'b0;
          nxt_bresp = mapped(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
        end
      end
      WR_RESP: begin
        if (bready) begin
          nxt_wr_state = WR_IDLE;
        end
      end
      default: begin
        nxt_wr_state = WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_ff <= WR_IDLE;
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_hold_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      bresp_ff <= RESP_OKAY;
    end else begin
      wr_state_ff <= nxt_wr_state;
      aw_hold_ff <= nxt_aw_hold;
      aw_addr_ff <= nxt_aw_addr;
      w_hold_ff <= nxt_w_hold;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
      bresp_ff <= nxt_bresp;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  assign arready = !rvalid_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (rvalid_ff && rready) begin
      nxt_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      nxt_rdata = 32'h0000_0000;
      if (hit(araddr, OFF_MASK)) begin
        nxt_rdata = mask_ff;
      end else if (hit(araddr, OFF_STATUS)) begin
        nxt_rdata = status;
      end else if (hit(araddr, OFF_THR)) begin
        nxt_rdata = {{(32-CNT_W){1'b0}}, thr_ff};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // ----------------------------------------------------------------
  // fifo bookkeeping and flags
  // ----------------------------------------------------------------
  assign wr_data = do_write && hit(aw_addr_ff, OFF_TXDATA) && (w_strb_ff != 4'h0);
  assign wr_clear = do_write && hit(aw_addr_ff, OFF_CLEAR);
  assign wr_ctrl = do_write && hit(aw_addr_ff, OFF_CTRL) && w_strb_ff[0];
  assign full_now = (cnt_ff == CNT_FULL);
  assign push_ok = wr_data && !full_now;
  assign overrun_set = wr_data && full_now;
  assign pop_ok = tx_pop && (cnt_ff != CNT_RST);
  assign clr_bits = wr_clear ? merge(32'h0000_0000, w_data_ff, w_strb_ff) : 32'h0000_0000;
  assign tx_push = push_ff;
  assign tx_word = txw_ff;
  assign tx_flush_bit = flush_ff;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_thr = thr_ff;
    nxt_mask = mask_ff;
    nxt_push = push_ok;
    nxt_txw = push_ok ? w_data_ff : txw_ff;
    nxt_flush = wr_ctrl && w_data_ff[BIT_FLUSH];
    if (nxt_flush) begin
      nxt_cnt = CNT_RST;
    end else if (push_ok && !pop_ok) begin
      nxt_cnt = cnt_ff + 5'h01;
    end else if (pop_ok && !push_ok) begin
      nxt_cnt = cnt_ff - 5'h01;
    end
    if (do_write && hit(aw_addr_ff, OFF_THR) && w_strb_ff[0]) begin
      nxt_thr = w_data_ff[CNT_W-1:0];
    end
    if (do_write && hit(aw_addr_ff, OFF_MASK)) begin
      nxt_mask = merge(mask_ff, w_data_ff, w_strb_ff) & MASK_RW;
    end
    // set wins over a clear in the same cycle
    nxt_ovr = (ovr_ff && !clr_bits[BIT_OVR]) || overrun_set;
    nxt_mdns = (mdns_ff && !clr_bits[BIT_MDNS]) || master_done_no_stop_event;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= CNT_RST;
      thr_ff <= THR_RST;
      mask_ff <= MASK_RST;
      ovr_ff <= OVR_RST;
      mdns_ff <= MDNS_RST;
      push_ff <= 1'b0;
      txw_ff <= 32'h0000_0000;
      flush_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      thr_ff <= nxt_thr;
      mask_ff <= nxt_mask;
      ovr_ff <= nxt_ovr;
      mdns_ff <= nxt_mdns;
      push_ff <= nxt_push;
      txw_ff <= nxt_txw;
      flush_ff <= nxt_flush;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_push_into_empty;
    wr_data && (cnt_ff == CNT_RST) && !tx_pop && !wr_ctrl;
  endsequence

  sequence s_push_to_full;
    wr_data && (cnt_ff == CNT_FULL - 5'h01) && !tx_pop && !wr_ctrl;
  endsequence

  a_reset_flags: assert property (
    $past(!aresetn) |-> status[BIT_EMPTY] && status[BIT_NEMPTY]
                        && !status[BIT_FULL] && !status[BIT_OVR])
    else $error("flags wrong after reset");

  a_empty_drop: assert property (
    s_push_into_empty |=> !status[BIT_EMPTY] ##0 tx_push)
    else $error("empty flag kept after write");

  a_nempty_thr: assert property (
    (cnt_ff == thr_ff + 5'h01) && pop_ok && !push_ok && !do_write |=> status[BIT_NEMPTY])
    else $error("nearly empty missing at threshold");

  a_nempty_rise: assert property (
    (cnt_ff == thr_ff) && push_ok && !pop_ok && !wr_ctrl |=> !status[BIT_NEMPTY])
    else $error("nearly empty kept above threshold");

  a_full_reach: assert property (
    s_push_to_full |=> status[BIT_FULL] ##1 (!status[BIT_FULL] || $stable(cnt_ff)))
    else $error("full flag not set");

  a_ovr_set: assert property (
    overrun_set && !wr_ctrl |=> status[BIT_OVR] && !tx_push
                                && (cnt_ff == ($past(tx_pop) ? CNT_FULL - 5'h01 : CNT_FULL)))
    else $error("overrun not flagged or word kept");

  a_ovr_hold: assert property (
    ovr_ff && !(wr_clear && w_data_ff[BIT_OVR] && w_strb_ff[0]) |=> ovr_ff)
    else $error("overrun dropped without clear");

  a_ovr_clear: assert property (
    ovr_ff && wr_clear && w_data_ff[BIT_OVR] && w_strb_ff[0] && !overrun_set |=> !ovr_ff)
    else $error("overrun not cleared");

  a_mask_top: assert property (
    rvalid_ff && $past(arvalid && arready && hit(araddr, OFF_MASK))
    |-> rdata_ff[31:29] == 3'h0)
    else $error("mask reserved bits read nonzero");

  a_irq_gate: assert property (
    master_done_no_stop_event && mask_ff[BIT_MDNS] && !(do_write && hit(aw_addr_ff, OFF_MASK))
    |=> irq)
    else $error("irq missing for enabled event");

endmodule
